// file: shared/small_ram_pkg.sv
// Constants, shapes, modes and control layout of the small RAM block.
package small_ram_pkg;

    // Storage geometry: 32 words of 18 bits, 576 bits with parity.
    localparam int WordBits = 18;
    localparam int WordCount = 32;
    localparam int WordIdxW = 5;
    localparam int AddrW = 9;
    localparam logic [9:0] TotalBits = 10'h240;
    localparam logic [9:0] PlainBits = 10'h200;
    localparam logic [9:0] ParityStride = 10'h012;

    // Register map, byte addresses on the APB side.
    localparam int ApbAddrW = 8;
    localparam logic [7:0] CtrlOff = 8'h00;
    localparam logic [7:0] StatusOff = 8'h04;
    localparam logic [7:0] InitAddrOff = 8'h08;
    localparam logic [7:0] InitDataOff = 8'h0c;

    // Status field positions.
    localparam int StatEmptyBit = 10;
    localparam int StatFullBit = 11;
    localparam int StatWrPendBit = 12;

    typedef enum logic [2:0] {
        ModeDual,
        ModeSingle,
        ModeFifo,
        ModeRom,
        ModeShift
    } mode_t;

    typedef enum logic [2:0] {
        Shape512x1,
        Shape256x2,
        Shape128x4,
        Shape64x8,
        Shape64x9,
        Shape32x16,
        Shape32x18
    } shape_t;

    // Control register layout, high bits first down to mode.
    typedef struct packed {
        logic swapClocks;
        logic ioClockMode;
        logic bypassOut;
        shape_t rdShape;
        shape_t wrShape;
        mode_t mode;
    } ctrl_t;

    localparam ctrl_t CtrlReset = '{
        swapClocks: 1'b0,
        ioClockMode: 1'b0,
        bypassOut: 1'b0,
        rdShape: Shape32x18,
        wrShape: Shape32x18,
        mode: ModeDual
    };
    localparam logic [4:0] InitAddrReset = 5'h00;
    localparam logic [9:0] CountReset = 10'h000;

endpackage

// file: hdl/small_ram_array.sv
// Storage array: 32 words of 18 bits, bit-masked write, registered read.
module small_ram_array (
    input wire logic clk,
    input wire logic wrEn,
    input wire logic [4:0] wrWord,
    input wire logic [17:0] wrData,
    input wire logic [17:0] wrMask,
    input wire logic rdEn,
    input wire logic [4:0] rdWord,
    output logic [17:0] rdData
);

    // Contents have no reset; a clear never touches the stored words.
    logic [17:0] mem [0:small_ram_pkg::WordCount-1];

    // Masked write lets narrow shapes update only their own bits.
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrWord] <= (mem[wrWord] & ~wrMask) | (wrData & wrMask);
        end
    end

    // A read of the word being written returns the old data.
    always_ff @(posedge clk) begin
        if (rdEn) begin
            rdData <= mem[rdWord];
        end
    end

endmodule

// file: hdl/small_ram_block.sv
// Small simple dual-port RAM block with APB control and user ports.
// Behaviour
// [R1] Simple dual-port memory; also single-port, FIFO, ROM or shift register.
// [R2] Storage holds 576 bits including parity bits.
// [R3] RAM or ROM contents can be preloaded before use.
// [R4] Write enable, data and address registers share one selected clock.
// [R5] Read address, read enable and output registers use either clock.
// [R6] Read/write or input/output clocking arrangement is selectable.
// [R7] Input registers always present; only output register may be bypassed.
// [R8] Surrounding logic drives strobes, clocks, enables and clears.
// [R9] Shapes 512x1 to 32x18; 9 and 18 bit shapes carry parity.
// [R10] Write and read ports may differ in width over shared storage.
// [R11] Write stores registered data when strobe and clock enable are high.
// [R12] Output clear zeroes the read output, memory contents untouched; with bypassOut set only outReg_q clears, rdData does not.
module small_ram_block (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tickA,
    input wire logic tickB,
    input wire logic clkEnA,
    input wire logic clkEnB,
    input wire logic wrEn,
    input wire logic [8:0] wrAddr,
    input wire logic [17:0] wrData,
    input wire logic rdEn,
    input wire logic [8:0] rdAddr,
    input wire logic outClr,
    input wire logic aclr,
    output logic [17:0] rdData,
    output logic fifoFull,
    output logic fifoEmpty
);

    // Port width in bits for a shape.
    function automatic logic [4:0] widthOf(small_ram_pkg::shape_t s);
        case (s)
            small_ram_pkg::Shape512x1: widthOf = 5'h01;
            small_ram_pkg::Shape256x2: widthOf = 5'h02;
            small_ram_pkg::Shape128x4: widthOf = 5'h04;
            small_ram_pkg::Shape64x8: widthOf = 5'h08;
            small_ram_pkg::Shape64x9: widthOf = 5'h09;
            small_ram_pkg::Shape32x16: widthOf = 5'h10;
            default: widthOf = 5'h12;
        endcase
    endfunction

    // Parity shapes use all 18 bits of a word, others only 16.
    function automatic logic isParity(small_ram_pkg::shape_t s);
        isParity = (s == small_ram_pkg::Shape64x9) ||
            (s == small_ram_pkg::Shape32x18);
    endfunction

    // Entry count for a shape; all are powers of two.
    function automatic logic [9:0] depthOf(small_ram_pkg::shape_t s);
        logic [9:0] bits;
        bits = isParity(s) ? small_ram_pkg::TotalBits // [R2]
            : small_ram_pkg::PlainBits;
        depthOf = 10'(bits / {5'h00, widthOf(s)});
    endfunction

    // Bit position of an entry; shared by both ports for consistent map.
    function automatic logic [9:0] bitOf(small_ram_pkg::shape_t s,
                                         logic [8:0] a);
        logic [9:0] d;
        d = depthOf(s) - 10'h001;
        bitOf = 10'(({1'b0, a} & d) * {5'h00, widthOf(s)});
    endfunction

    function automatic logic [4:0] wordOf(small_ram_pkg::shape_t s,
                                          logic [8:0] a);
        logic [9:0] b;
        b = bitOf(s, a);
        wordOf = isParity(s) ? 5'(b / small_ram_pkg::ParityStride)
            : b[8:4];
    endfunction

    function automatic logic [4:0] offOf(small_ram_pkg::shape_t s,
                                         logic [8:0] a);
        logic [9:0] b;
        b = bitOf(s, a);
        offOf = isParity(s) ? 5'(b % small_ram_pkg::ParityStride)
            : {1'b0, b[3:0]};
    endfunction

    function automatic logic [17:0] maskOf(small_ram_pkg::shape_t s);
        maskOf = 18'((19'h00001 << widthOf(s)) - 19'h00001);
    endfunction

    small_ram_pkg::ctrl_t ctrl_q;
    logic [4:0] initAddr_q;
    logic [31:0] prdata_q;
    logic [9:0] count_q;
    logic [8:0] wrPtr_q;
    logic [8:0] rdPtr_q;
    logic wrPend_q;
    logic [4:0] wrWord_q;
    logic [17:0] wrBits_q;
    logic [17:0] wrMask_q;
    logic rdPend_q;
    logic [4:0] rdWord_q;
    logic [4:0] rdOff_q;
    logic [4:0] rdOffHeld_q;
    logic [17:0] outReg_q;
    logic [17:0] arrayData;

    // Effective clock ticks; each raw tick is qualified here by its own clock enable.
    wire tickAEff = tickA && clkEnA; // [R8]
    wire tickBEff = tickB && clkEnB; // [R8]
    wire firstTick = ctrl_q.swapClocks ? tickBEff : tickAEff;
    wire secondTick = ctrl_q.swapClocks ? tickAEff : tickBEff;

    // Write side always on the first clock; read side follows the mode.
    wire wrTick = firstTick; // [R4]
    wire rdTick = ctrl_q.ioClockMode ? firstTick : secondTick; // [R5] [R6]
    wire outTick = secondTick; // [R5] [R6]

    // Mode decode.
    wire modeFifo = ctrl_q.mode == small_ram_pkg::ModeFifo; // [R1]
    wire modeShift = ctrl_q.mode == small_ram_pkg::ModeShift; // [R1]
    wire modeRom = ctrl_q.mode == small_ram_pkg::ModeRom; // [R1]
    wire modeSingle = ctrl_q.mode == small_ram_pkg::ModeSingle; // [R1]
    wire usePtr = modeFifo || modeShift;
    wire [9:0] fifoDepth = depthOf(ctrl_q.wrShape);
    wire isFull = modeFifo && (count_q == fifoDepth);
    wire isEmpty = count_q == small_ram_pkg::CountReset;

    // APB decode; the slave always answers in the access cycle.
    wire apbWrite = psel && penable && pwrite;
    wire apbSetup = psel && !penable;
    wire hitCtrl = paddr == small_ram_pkg::CtrlOff;
    wire hitStatus = paddr == small_ram_pkg::StatusOff;
    wire hitInitAddr = paddr == small_ram_pkg::InitAddrOff;
    wire hitInitData = paddr == small_ram_pkg::InitDataOff;
    wire hitAny = hitCtrl || hitStatus || hitInitAddr || hitInitData;
    wire ctrlWrite = apbWrite && hitCtrl;
    wire initWrite = apbWrite && hitInitData; // [R3]
    wire [31:0] statusWord = {19'h00000, wrPend_q, isFull, isEmpty,
        count_q};
    wire [31:0] readMux = hitCtrl ? {20'h00000, ctrl_q}
        : hitStatus ? statusWord
        : hitInitAddr ? {27'h0000000, initAddr_q}
        : 32'h00000000;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hitAny;
    assign prdata = prdata_q;

    // Write request: ROM refuses user writes, FIFO refuses when full.
    wire wrAccept = wrTick && wrEn && !modeRom && !isFull; // [R11]
    wire [8:0] wrAddrSel = usePtr ? wrPtr_q : wrAddr;
    wire [4:0] wrOff = offOf(ctrl_q.wrShape, wrAddrSel); // [R10]
    wire [17:0] wrBitsD = (wrData & maskOf(ctrl_q.wrShape)) << wrOff;
    wire [17:0] wrMaskD = maskOf(ctrl_q.wrShape) << wrOff; // [R9]

    // Read request: single port reads at the write address, shift
    // register reads the oldest entry at the write pointer.
    wire rdAccept = modeShift ? wrAccept
        : (rdTick && rdEn && !(modeFifo && isEmpty)); // [R1]
    wire [8:0] rdAddrSel = modeShift ? wrPtr_q
        : modeFifo ? rdPtr_q
        : modeSingle ? wrAddr : rdAddr;
    wire [9:0] rdAddrBits = {1'b0, rdAddrSel}; // Keeps width explicit.

    // Array port: an init load takes the port, a user write waits.
    wire userWrGo = wrPend_q && !initWrite;
    wire arrWrEn = initWrite || userWrGo;
    wire [4:0] arrWrWord = initWrite ? initAddr_q : wrWord_q;
    wire [17:0] arrWrData = initWrite ? pwdata[17:0] : wrBits_q;
    wire [17:0] arrWrMask = initWrite ? 18'h3ffff : wrMask_q;

    small_ram_array array (
        .clk(clk),
        .wrEn(arrWrEn),
        .wrWord(arrWrWord),
        .wrData(arrWrData),
        .wrMask(arrWrMask),
        .rdEn(rdPend_q),
        .rdWord(rdWord_q),
        .rdData(arrayData)
    );

    // Pick the read entry out of the array word for the read shape.
    wire [17:0] rdField = (arrayData >> rdOffHeld_q) &
        maskOf(ctrl_q.rdShape); // [R10]

    // Data out: output register or its bypass straight from the array.
    assign rdData = ctrl_q.bypassOut ? rdField : outReg_q; // [R7]
    assign fifoFull = isFull;
    assign fifoEmpty = isEmpty;

    // Control register; a write restarts the FIFO pointers.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= small_ram_pkg::CtrlReset;
        end else if (ctrlWrite) begin
            ctrl_q <= small_ram_pkg::ctrl_t'(pwdata[11:0]); // [R6] [R9]
        end
    end

    // Init pointer walks one word per load so a table streams in.
    always_ff @(posedge clk) begin
        if (rst) begin
            initAddr_q <= small_ram_pkg::InitAddrReset;
        end else if (apbWrite && hitInitAddr) begin
            initAddr_q <= pwdata[4:0]; // [R3]
        end else if (initWrite) begin
            initAddr_q <= initAddr_q + 5'h01; // [R3]
        end
    end

    // Read data sampled in the setup cycle, stable through access.
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_q <= 32'h00000000;
        end else if (apbSetup) begin
            prdata_q <= readMux;
        end
    end

    // Write input registers, all loaded on the same write tick.
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
        end else if (wrAccept) begin
            wrPend_q <= 1'b1; // [R4] [R11]
        end else if (userWrGo) begin
            wrPend_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrWord_q <= 5'h00;
            wrBits_q <= 18'h00000;
            wrMask_q <= 18'h00000;
        end else if (wrAccept) begin
            wrWord_q <= wordOf(ctrl_q.wrShape, wrAddrSel); // [R4] [R10]
            wrBits_q <= wrBitsD; // [R4]
            wrMask_q <= wrMaskD; // [R4]
        end
    end

    // Read address and enable registers, always present.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdPend_q <= 1'b0;
            rdWord_q <= 5'h00;
            rdOff_q <= 5'h00;
        end else begin
            rdPend_q <= rdAccept; // [R5] [R7]
            if (rdAccept) begin
                rdWord_q <= wordOf(ctrl_q.rdShape, rdAddrBits[8:0]);
                rdOff_q <= offOf(ctrl_q.rdShape, rdAddrBits[8:0]);
            end
        end
    end

    // Offset is loaded on the same edge as the array read to line up with it.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdOffHeld_q <= 5'h00;
        end else if (rdPend_q) begin
            rdOffHeld_q <= rdOff_q;
        end
    end

    // Output register: clears win over a load and leave memory alone.
    always_ff @(posedge clk) begin
        if (rst || outClr || aclr) begin
            outReg_q <= 18'h00000; // [R12]
        end else if (outTick) begin
            outReg_q <= rdField; // [R5]
        end
    end

    // FIFO and shift pointers wrap at the depth of the write shape.
    always_ff @(posedge clk) begin
        if (rst || ctrlWrite) begin
            wrPtr_q <= 9'h000;
            rdPtr_q <= 9'h000;
        end else begin
            if (usePtr && wrAccept) begin
                wrPtr_q <= 9'((wrPtr_q + 9'h001) & 9'(fifoDepth - 10'h001));
            end
            if (modeFifo && rdAccept) begin
                rdPtr_q <= 9'((rdPtr_q + 9'h001) & 9'(fifoDepth - 10'h001));
            end
        end
    end

    // Entry count; a write and a read in one cycle cancel out.
    always_ff @(posedge clk) begin
        if (rst || ctrlWrite) begin
            count_q <= small_ram_pkg::CountReset;
        end else if (modeFifo) begin
            if (wrAccept && !rdAccept) begin
                count_q <= count_q + 10'h001; // [R1]
            end else if (rdAccept && !wrAccept) begin
                count_q <= count_q - 10'h001; // [R1]
            end
        end
    end

endmodule

// file: dv/fabric_user.sv
// Fabric-side model that makes the two clock ticks of the small RAM block.
module fabric_user (
    input wire logic clk,
    input wire logic slowB,
    output logic tickA,
    output logic tickB
);
    timeunit 1ns;
    timeprecision 1ns;
    logic phase_q = 1'b0;
    // Phase flop lets tick B run at half rate, like a slower fabric clock.
    always_ff @(posedge clk) begin
        phase_q <= !phase_q;
    end
    // Tick A is free running; tick B skips every other cycle when slow.
    assign tickA = 1'b1;
    assign tickB = !slowB || phase_q;
endmodule

// file: dv/small_ram_block_asserts.sv
// Port-level concurrent checks for the small RAM block.
module small_ram_block_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic wrEn,
    input wire logic outClr,
    input wire logic aclr,
    input wire logic [17:0] rdData,
    input wire logic fifoFull,
    input wire logic fifoEmpty
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Mapped words are the four aligned offsets at the bottom of the map.
    wire access = psel && penable;
    wire mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'b00;
    property p_clrOut;
        (outClr || aclr) |=> rdData == 18'h0;
    endproperty
    a_clrOut: assert property (p_clrOut) else $error("kept data");
    property p_clrHold;
        outClr [*2] |-> rdData == 18'h0;
    endproperty
    a_clrHold: assert property (p_clrHold) else $error("clear hold");
    // Reset is the subject here, so this one is never disabled.
    property p_rstOut;
        disable iff (1'b0) rst |=> rdData == 18'h0 && fifoEmpty && !fifoFull;
    endproperty
    a_rstOut: assert property (p_rstOut) else $error("reset state");
    property p_exclusive;
        !(fifoFull && fifoEmpty);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("both set");
    property p_errMap;
        access && !mapped |-> pslverr;
    endproperty
    a_errMap: assert property (p_errMap) else $error("no error");
    property p_errOnly;
        pslverr |-> access && !mapped;
    endproperty
    a_errOnly: assert property (p_errOnly) else $error("stray error");
    property p_prdataErr;
        access && !mapped && !pwrite |-> prdata == 32'h0;
    endproperty
    a_prdataErr: assert property (p_prdataErr) else $error("bad data");
    // Occupancy may only grow shortly after a write strobe.
    property p_emptyFall;
        $fell(fifoEmpty) |-> $past(wrEn) || $past(wrEn, 2) || $past(wrEn, 3);
    endproperty
    a_emptyFall: assert property (p_emptyFall) else $error("fill");
    property p_fullRise;
        $rose(fifoFull) |-> $past(wrEn) || $past(wrEn, 2) || $past(wrEn, 3);
    endproperty
    a_fullRise: assert property (p_fullRise) else $error("full");
    c_err: cover property (access && !mapped);
    c_full: cover property (fifoFull);
    c_clr: cover property (outClr ##1 rdData == 18'h0);
endmodule
bind small_ram_block small_ram_block_asserts u_chk (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .prdata, .pslverr, .wrEn, .outClr, .aclr,
    .rdData, .fifoFull, .fifoEmpty);

// file: dv/test_small_ram_block.sv
// Self-checking bench for the small RAM block, its ports and registers.
module test_small_ram_block;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [8:0] a; logic [17:0] d;} row_t;
    localparam row_t Rows [4] = '{'{9'h000, 18'h3ffff},
        '{9'h01f, 18'h20001}, '{9'h00a, 18'h15555}, '{9'h011, 18'h0aaaa}};
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err, tickA, tickB;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic clkEnA = 1'b1, clkEnB = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
    logic outClr = 1'b0, aclr = 1'b0, slowB = 1'b0, fifoFull, fifoEmpty;
    logic [8:0] wrAddr = 9'h000, rdAddr = 9'h000;
    logic [17:0] wrData = 18'h0, rdData;
    int n_mismatch = 0, n_tests = 0;
    small_ram_block DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tickA, .tickB, .clkEnA,
        .clkEnB, .wrEn, .wrAddr, .wrData, .rdEn, .rdAddr, .outClr, .aclr,
        .rdData, .fifoFull, .fifoEmpty);
    fabric_user user (.clk, .slowB, .tickA, .tickB);
    always #20 clk = !clk;
    task automatic report_and_stop();
        $display("counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request is held until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            n_mismatch++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // User write on the always-running write tick, then let it land.
    task automatic uwr(input logic [8:0] a, input logic [17:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        wrAddr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // Read strobe stays up until a read tick takes it; slow ticks need this.
    task automatic urd(input logic [8:0] a, input logic [17:0] exp);
        int i;
        @(posedge clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            if (tickB === 1'b1) break;
        end
        if (i == 8) begin
            n_mismatch++;
            report_and_stop();
        end
        rdEn <= 1'b0;
        repeat (6) @(posedge clk);
        chk({14'h0, rdData}, {14'h0, exp});
    endtask
    // Main sequence: reset state first, then table rows, then the awkward cases.
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk({14'h0, rdData}, 32'h0);
        apb(1'b0, small_ram_pkg::CtrlOff, 32'h0);
        chk(rd, 32'h1b0);
        apb(1'b0, small_ram_pkg::StatusOff, 32'h0);
        chk(rd, 32'h400);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
        foreach (Rows[k]) uwr(Rows[k].a, Rows[k].d);
        foreach (Rows[k]) urd(Rows[k].a, Rows[k].d);
        $display("test rows done");
        clkEnA <= 1'b0;
        uwr(9'h000, 18'h00123);
        clkEnA <= 1'b1;
        urd(9'h000, 18'h3ffff);
        for (int c = 0; c < 2; c++) begin
            urd(9'h00a, 18'h15555);
            outClr <= c == 0;
            aclr <= c == 1;
            @(posedge clk);
            outClr <= 1'b0;
            aclr <= 1'b0;
            @(posedge clk);
            chk({14'h0, rdData}, 32'h0);
        end
        urd(9'h00a, 18'h15555);
        $display("test clear done");
        // Bypass shows the array word while the output register, its
        // clock gated off, keeps the cleared value underneath.
        clkEnB <= 1'b0;
        outClr <= 1'b1;
        repeat (2) @(posedge clk);
        outClr <= 1'b0;
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h7b0);
        urd(9'h00a, 18'h15555);
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h5b0);
        @(posedge clk);
        chk({14'h0, rdData}, 32'h0);
        // Swapped clocks put the write side on the gated clock B.
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h9b0);
        uwr(9'h01f, 18'h00000);
        clkEnB <= 1'b1;
        urd(9'h01f, 18'h20001);
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h1b0);
        $display("test bypass done");
        slowB <= 1'b1;
        uwr(9'h011, 18'h0c3c3);
        urd(9'h011, 18'h0c3c3);
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h5b0);
        urd(9'h01f, 18'h20001);
        slowB <= 1'b0;
        $display("test clocking done");
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h1b3);
        apb(1'b1, small_ram_pkg::InitAddrOff, 32'h5);
        apb(1'b1, small_ram_pkg::InitDataOff, 32'h2a5c3);
        apb(1'b1, small_ram_pkg::InitDataOff, 32'h1e0f0);
        apb(1'b0, small_ram_pkg::InitAddrOff, 32'h0);
        chk(rd, 32'h7);
        uwr(9'h005, 18'h0);
        urd(9'h005, 18'h2a5c3);
        urd(9'h006, 18'h1e0f0);
        $display("test preload done");
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h130);
        urd(9'h00a, 18'h001c3);
        urd(9'h00b, 18'h00152);
        for (int s = 0; s < 7; s++) begin
            apb(1'b1, small_ram_pkg::CtrlOff, 32'(s * 72));
            apb(1'b0, small_ram_pkg::CtrlOff, 32'h0);
            chk(rd, 32'(s * 72));
        end
        $display("test shapes done");
        // Single port reads at the write address, not the read address.
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h1b1);
        uwr(9'h003, 18'h0abcd);
        urd(9'h000, 18'h0abcd);
        // Shift register hands an entry back after a full turn of depth.
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h1b4);
        for (int i = 0; i < 33; i++) uwr(9'h000, 18'(i + 256));
        @(posedge clk);
        chk({14'h0, rdData}, 32'h100);
        $display("test modes done");
        apb(1'b1, small_ram_pkg::CtrlOff, 32'h1b2);
        for (int i = 0; i < 32; i++) uwr(9'(i), 18'(i + 7));
        chk({31'h0, fifoFull}, 32'h1);
        apb(1'b0, small_ram_pkg::StatusOff, 32'h0);
        chk(rd, 32'h820);
        uwr(9'h000, 18'h3ffff);
        urd(9'h000, 18'h00007);
        urd(9'h000, 18'h00008);
        $display("test fifo done");
        // Reset in mid-run clears the state but keeps the stored words.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chk({30'h0, fifoFull, fifoEmpty}, 32'h1);
        chk({14'h0, rdData}, 32'h0);
        apb(1'b0, small_ram_pkg::CtrlOff, 32'h0);
        chk(rd, 32'h1b0);
        urd(9'h001, 18'h00008);
        $display("test reset again done");
        report_and_stop();
    end
endmodule
